//--- rtl/dsp_sdram.v
`include "dsp_consts.vh"
`default_nettype none

// Notes on behaviour
// - Hot self refresh allowed only with extended mode reg two bit 7 set.
// - Activate takes a 14-bit row from address lines 0 to 13.
// - Read/write take column from lines 0 to 9; line 10 is auto precharge.
// - Three bank select lines pick one of eight banks.
// - Termination control registered high enables termination, low disables.
// - Strobe edge-aligned with read data, centred in write data eye.
// - Lower strobe times lines 0-7, upper strobe times lines 8-15; here an edge on either strobe captures all 16 write lines.
// - Complement strobes used only when extended mode reg one bit 10 set.
// - Commands ignored when active-low chip select registered high.
// - Command decoded from chip select, row, column strobe, write enable.
// - A write beat with its byte mask high is not stored, per byte.
// - Byte masks sampled on both strobe edges like write data.
// - Address and control registered on rising edge of true clock.
// - Read data driven on both clock edges, two transfers per cycle.
// - Clock enable registered high runs internal clocking; low stops it.
module dsp_sdram (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // Memory clock and command pins
  input  wire        memClk,
  input  wire        clockEnable,
  input  wire        chipSelectN,
  input  wire        rowStrobeN,
  input  wire        colStrobeN,
  input  wire        writeEnableN,
  input  wire [2:0]  bank_select,
  input  wire [13:0] address,
  input  wire        termination_control,
  // Data pins
  input  wire [15:0] dataIn,
  output reg  [15:0] dataOut,
  output reg         dataOeN,
  input  wire        lower_byte_mask,
  input  wire        upper_byte_mask,
  input  wire        lowerStrobeIn,
  input  wire        upperStrobeIn,
  output reg         lower_byte_strobe,
  output reg         upper_byte_strobe,
  output reg         lowerStrobeCompl,
  output reg         upperStrobeCompl,
  output reg         strobeOeN,
  output reg         complStrobeOeN,
  // Status
  input  wire        caseHot,
  output reg         terminationOn,
  output reg         selfRefreshOn,
  output reg         hotSelfRefreshOn,
  output reg         refreshLate
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [28:0] pinSync;
  dsp_sync2 #(.W(29)) uSync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({memClk, clockEnable, chipSelectN, rowStrobeN, colStrobeN, writeEnableN,
            bank_select, address, termination_control, lowerStrobeIn, upperStrobeIn,
            lower_byte_mask, upper_byte_mask, caseHot}),
    .dout (pinSync)
  );
  wire       sClk   = pinSync[28];
  wire       sCke   = pinSync[27];
  wire [3:0] sCmd   = pinSync[26:23];
  wire [2:0] sBank  = pinSync[22:20];
  wire [13:0] sAddr = pinSync[19:6];
  wire       sOdt   = pinSync[5];
  wire       sLdqs  = pinSync[4];
  wire       sUdqs  = pinSync[3];
  wire       sLdm   = pinSync[2];
  wire       sUdm   = pinSync[1];
  wire       sHot   = pinSync[0];
  wire [15:0] sData;
  dsp_sync2 #(.W(16)) uDataSync (
    .clk  (clk),
    .nrst (nrst),
    .din  (dataIn),
    .dout (sData)
  );

  // ----------------------------------------------------------------
  // Edge detection on the memory clock and strobes
  // ----------------------------------------------------------------
  reg  clkPrev_q;
  reg  ldqsPrev_q;
  reg  udqsPrev_q;
  wire clkRise = sClk && !clkPrev_q;
  wire clkFall = !sClk && clkPrev_q;
  wire ldqsEdge = sLdqs ^ ldqsPrev_q;
  wire udqsEdge = sUdqs ^ udqsPrev_q;

  // ----------------------------------------------------------------
  // Device state
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_WRITE = 4'h2;
  localparam [3:0] ST_READ  = 4'h4;
  localparam [3:0] ST_SREF  = 4'h8;

  reg [3:0]  state_q;
  reg        ckeReg_q;
  reg [13:0] rowOpen_q [0:7];
  reg [7:0]  bankOpen_q;
  reg [13:0] emr1_q;
  reg [13:0] emr2_q;
  reg [2:0]  burstBank_q;
  reg [9:0]  burstCol_q;
  reg        burstAp_q;
  reg [2:0]  beat_q;
  reg [2:0]  latency_q;
  reg [15:0] refCount_q;
  reg [`DSP_MEM_AW-1:0] rdAddr_q;
  reg [15:0] mem [0:(1<<`DSP_MEM_AW)-1];

  wire [31:0] refLimitWide = sHot ? `DSP_REFI_HOT_CY : `DSP_REFI_NORM_CY;
  wire [15:0] refLimit = refLimitWide[15:0];
  wire        diffStrobe = emr1_q[`DSP_EMR1_DIFF];
  wire        hotSrAllowed = emr2_q[`DSP_EMR2_HTSR];
  wire        cmdValid = clkRise && ckeReg_q && !sCmd[3];
  wire [`DSP_MEM_AW-1:0] beatAddr = {burstBank_q, burstCol_q[4:0] + {2'h0, beat_q}};

  // Write beats pass through the FIFO before reaching the array
  wire        fifoInReady;
  wire        fifoOutValid;
  wire [17+`DSP_MEM_AW:0] fifoOut;
  wire        wrBeat = (state_q == ST_WRITE) && (ldqsEdge || udqsEdge);
  dsp_fifo #(.W(18 + `DSP_MEM_AW), .D(`DSP_FIFO_DEPTH), .AW(`DSP_FIFO_AW)) uFifo (
    .clk      (clk),
    .nrst     (nrst),
    .inValid  (wrBeat),
    .inReady  (fifoInReady),
    .inData   ({beatAddr, sUdm, sLdm, sData}),
    .outValid (fifoOutValid),
    .outReady (1'b1),
    .outData  (fifoOut)
  );

  // Each byte lane keeps its old contents when its own mask is high
  wire [`DSP_MEM_AW-1:0] wrAddr = fifoOut[17+`DSP_MEM_AW:18];
  wire [15:0]            wrWord;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gLane
      assign wrWord[8*g+7:8*g] = fifoOut[16+g] ? mem[wrAddr][8*g+7:8*g]
                                               : fifoOut[8*g+7:8*g];
    end
  endgenerate

  always @(posedge clk) begin
    if (fifoOutValid) begin
      mem[wrAddr] <= wrWord;
    end
  end

  integer i;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clkPrev_q   <= 1'b0;
      ldqsPrev_q  <= 1'b0;
      udqsPrev_q  <= 1'b0;
      state_q     <= ST_IDLE;
      ckeReg_q    <= 1'b0;
      bankOpen_q  <= 8'h00;
      emr1_q      <= 14'h0000;
      emr2_q      <= 14'h0000;
      burstBank_q <= 3'h0;
      burstCol_q  <= 10'h000;
      burstAp_q   <= 1'b0;
      beat_q      <= 3'h0;
      latency_q   <= 3'h0;
      refCount_q  <= 16'h0000;
      rdAddr_q    <= {`DSP_MEM_AW{1'b0}};
      for (i = 0; i < 8; i = i + 1) begin
        rowOpen_q[i] <= 14'h0000;
      end
    end else begin
      clkPrev_q  <= sClk;
      ldqsPrev_q <= sLdqs;
      udqsPrev_q <= sUdqs;
      if (clkRise) begin
        ckeReg_q <= sCke;
      end
      // Counts system clocks so the limit does not depend on the link rate
      if (refCount_q != 16'hFFFF) begin
        refCount_q <= refCount_q + 16'h0001;
      end
      case (state_q)
        ST_IDLE: begin
          if (clkRise && !sCke && ckeReg_q && sCmd == `DSP_CMD_REFRESH) begin
            state_q    <= ST_SREF;
            refCount_q <= 16'h0000;
          end else if (cmdValid) begin
            case (sCmd)
              `DSP_CMD_ACTIVATE: begin
                rowOpen_q[sBank]  <= sAddr;
                bankOpen_q[sBank] <= 1'b1;
              end
              `DSP_CMD_PRECHG: begin
                if (sAddr[`DSP_AP_BIT]) begin
                  bankOpen_q <= 8'h00;
                end else begin
                  bankOpen_q[sBank] <= 1'b0;
                end
              end
              `DSP_CMD_WRITE: begin
                burstBank_q <= sBank;
                burstCol_q  <= sAddr[`DSP_COL_W-1:0];
                burstAp_q   <= sAddr[`DSP_AP_BIT];
                beat_q      <= 3'h0;
                state_q     <= ST_WRITE;
              end
              `DSP_CMD_READ: begin
                burstBank_q <= sBank;
                burstCol_q  <= sAddr[`DSP_COL_W-1:0];
                burstAp_q   <= sAddr[`DSP_AP_BIT];
                beat_q      <= 3'h0;
                latency_q   <= 3'h0;
                rdAddr_q    <= {sBank, sAddr[4:0]};
                state_q     <= ST_READ;
              end
              `DSP_CMD_REFRESH: begin
                refCount_q <= 16'h0000;
              end
              `DSP_CMD_MRS: begin
                if (sBank == `DSP_BANK_EMR1) begin
                  emr1_q <= sAddr;
                end else if (sBank == `DSP_BANK_EMR2) begin
                  emr2_q <= sAddr;
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_WRITE: begin
          if (wrBeat && fifoInReady) begin
            beat_q <= beat_q + 3'h1;
            if (beat_q == `DSP_BURST_BEATS - 1) begin
              state_q <= ST_IDLE;
              if (burstAp_q) begin
                bankOpen_q[burstBank_q] <= 1'b0;
              end
            end
          end
        end
        ST_READ: begin
          if (clkRise && latency_q != `DSP_READ_LAT) begin
            latency_q <= latency_q + 3'h1;
          end else if ((clkRise || clkFall) && latency_q == `DSP_READ_LAT) begin
            beat_q   <= beat_q + 3'h1;
            rdAddr_q <= beatAddr + 1'b1;
            if (beat_q == `DSP_BURST_BEATS - 1) begin
              state_q <= ST_IDLE;
              if (burstAp_q) begin
                bankOpen_q[burstBank_q] <= 1'b0;
              end
            end
          end
        end
        ST_SREF: begin
          refCount_q <= 16'h0000;
          if (clkRise && sCke) begin
            state_q  <= ST_IDLE;
            ckeReg_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers and status, all registered
  // ----------------------------------------------------------------
  wire readDrive = (state_q == ST_READ) && (latency_q == `DSP_READ_LAT);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataOut           <= 16'h0000;
      dataOeN           <= 1'b1;
      lower_byte_strobe <= 1'b0;
      upper_byte_strobe <= 1'b0;
      lowerStrobeCompl  <= 1'b1;
      upperStrobeCompl  <= 1'b1;
      strobeOeN         <= 1'b1;
      complStrobeOeN    <= 1'b1;
      terminationOn     <= 1'b0;
      selfRefreshOn     <= 1'b0;
      hotSelfRefreshOn  <= 1'b0;
      refreshLate       <= 1'b0;
    end else begin
      // Strobe edges launch with the data so they stay edge aligned
      dataOeN           <= !readDrive;
      strobeOeN         <= !readDrive;
      complStrobeOeN    <= !(readDrive && diffStrobe);
      // Delayed clock sample matches the one-cycle address-to-data lag
      dataOut           <= mem[rdAddr_q];
      lower_byte_strobe <= readDrive ? clkPrev_q : 1'b0;
      upper_byte_strobe <= readDrive ? clkPrev_q : 1'b0;
      lowerStrobeCompl  <= readDrive ? !clkPrev_q : 1'b1;
      upperStrobeCompl  <= readDrive ? !clkPrev_q : 1'b1;
      if (clkRise && ckeReg_q) begin
        terminationOn <= sOdt;
      end
      selfRefreshOn    <= (state_q == ST_SREF);
      hotSelfRefreshOn <= (state_q == ST_SREF) && sHot && hotSrAllowed;
      refreshLate      <= (refCount_q > refLimit);
    end
  end

endmodule

`default_nettype wire

//--- common/dsp_consts.vh
`ifndef DSP_CONSTS_VH
`define DSP_CONSTS_VH

// ----------------------------------------------------------------
// Command codes {chip select, row strobe, column strobe, write enable}
// ----------------------------------------------------------------
`define DSP_CMD_MRS      4'h0
`define DSP_CMD_REFRESH  4'h1
`define DSP_CMD_PRECHG   4'h2
`define DSP_CMD_ACTIVATE 4'h3
`define DSP_CMD_WRITE    4'h4
`define DSP_CMD_READ     4'h5
`define DSP_CMD_NOP      4'h7

// ----------------------------------------------------------------
// Address field positions
// ----------------------------------------------------------------
`define DSP_ROW_W        14
`define DSP_COL_W        10
`define DSP_AP_BIT       10
`define DSP_EMR1_DIFF    10
`define DSP_EMR2_HTSR    7
`define DSP_BANK_MODE    3'h0
`define DSP_BANK_EMR1    3'h1
`define DSP_BANK_EMR2    3'h2

// ----------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------
`define DSP_BURST_BEATS  4
`define DSP_READ_LAT     3
`define DSP_MEM_AW       8
`define DSP_FIFO_DEPTH   16
`define DSP_FIFO_AW      4
`define DSP_CLK_NS       10
`define DSP_REFI_NORM_NS 7800
`define DSP_REFI_HOT_NS  3900
`define DSP_REFI_NORM_CY (`DSP_REFI_NORM_NS / `DSP_CLK_NS)
`define DSP_REFI_HOT_CY  (`DSP_REFI_HOT_NS / `DSP_CLK_NS)

`endif

//--- rtl/dsp_sync2.v
`default_nettype none

module dsp_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         nrst,
  // Data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] meta_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

`default_nettype wire

//--- rtl/dsp_fifo.v
`default_nettype none

module dsp_fifo #(
  parameter W  = 18,
  parameter D  = 16,
  parameter AW = 4
) (
  // Clock and reset
  input  wire         clk,
  input  wire         nrst,
  // Fill side
  input  wire         inValid,
  output wire         inReady,
  input  wire [W-1:0] inData,
  // Drain side
  output wire         outValid,
  input  wire         outReady,
  output wire [W-1:0] outData
);

  reg [W-1:0] mem [0:D-1];
  reg [AW:0]  wrPtr_q;
  reg [AW:0]  rdPtr_q;
  wire        full;
  wire        empty;

  assign full     = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty    = (wrPtr_q == rdPtr_q);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  always @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else begin
      if (inValid && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- dv/dsp_sdram_assertions.sv
`default_nettype none
module dsp_sdram_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Read drive
  input wire logic        dataOeN,
  input wire logic        strobeOeN,
  input wire logic        complStrobeOeN,
  input wire logic [15:0] dataOut,
  input wire logic        lower_byte_strobe,
  input wire logic        upper_byte_strobe,
  input wire logic        lowerStrobeCompl,
  input wire logic        upperStrobeCompl,
  // Status
  input wire logic        selfRefreshOn,
  input wire logic        hotSelfRefreshOn
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  compl_needs_true_a: assert property (!complStrobeOeN |-> !strobeOeN)
    else $error("complement strobe driven alone");
  compl_inverse_a: assert property (!complStrobeOeN |->
    lowerStrobeCompl != lower_byte_strobe && upperStrobeCompl != upper_byte_strobe)
    else $error("complement strobe not inverted");
  read_oe_pair_a: assert property ($fell(dataOeN) |-> !strobeOeN)
    else $error("read data driven without strobe");
  read_hold_a: assert property ($fell(dataOeN) |=> !dataOeN [*8])
    else $error("read burst released early");
  read_release_a: assert property ($fell(dataOeN) |-> ##[24:40] $rose(dataOeN))
    else $error("read burst not released in time");
  release_pair_a: assert property ($rose(dataOeN) |-> strobeOeN)
    else $error("strobe kept after data release");
  strobe_pair_a: assert property (!strobeOeN |-> lower_byte_strobe == upper_byte_strobe)
    else $error("byte strobes disagree");
  edge_align_a: assert property (!dataOeN && $past(!dataOeN) && $changed(dataOut)
    |-> $changed(lower_byte_strobe))
    else $error("read data moved without strobe edge");
  hot_sr_a: assert property (hotSelfRefreshOn |-> selfRefreshOn)
    else $error("hot self refresh outside self refresh");
endmodule

bind dsp_sdram dsp_sdram_chk chk_u (.*);
`default_nettype wire

//--- dv/dsp_ctrl_model.sv
`include "dsp_consts.vh"
`default_nettype none
module dsp_ctrl_model (
  // Clock
  input  wire logic        clk,
  // Command pins
  output var  logic        memClk,
  output var  logic        clockEnable,
  output var  logic        chipSelectN,
  output var  logic        rowStrobeN,
  output var  logic        colStrobeN,
  output var  logic        writeEnableN,
  output var  logic [2:0]  bank_select,
  output var  logic [13:0] address,
  // Write data
  output var  logic        wdrive,
  output var  logic [15:0] wdata,
  output var  logic        lower_byte_mask,
  output var  logic        upper_byte_mask,
  output var  logic        lowerStrobeIn,
  output var  logic        upperStrobeIn
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {memClk, wdrive, lower_byte_mask, upper_byte_mask, lowerStrobeIn, upperStrobeIn} = 6'h00;
    clockEnable = 1'b1;
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = 4'hF;
    bank_select = 3'h0;
    address = 14'h0000;
    wdata = 16'h0000;
  end
  // ----
  // Link clock stands still between frames
  // ----
  task automatic tick(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      #1 memClk = 1'b1;
      repeat (8) @(posedge clk);
      #1 memClk = 1'b0;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
                     input logic ce);
    // A fresh time step so the no-op of the last call is not overwritten at once
    @(posedge clk);
    #1;
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = c;
    bank_select = b;
    address = a;
    clockEnable = ce;
    tick(1);
    {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = `DSP_CMD_NOP;
  endtask
  // Strobe toggles mid-eye so data and mask are stable both sides
  task automatic burst(input logic [63:0] d, input logic [7:0] m);
    wdrive = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wdata = d[16*i +: 16];
      {upper_byte_mask, lower_byte_mask} = m[2*i +: 2];
      repeat (4) @(posedge clk);
      #1 lowerStrobeIn = !lowerStrobeIn;
      upperStrobeIn = !upperStrobeIn;
      repeat (4) @(posedge clk);
      #1;
    end
    {wdrive, lower_byte_mask, upper_byte_mask} = 3'h0;
  endtask
endmodule
`default_nettype wire

//--- dv/dsp_sdram_test.sv
`include "dsp_consts.vh"
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (e)); end end
module dsp_sdram_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] A = 64'h4444_3333_2222_1111;
  localparam logic [63:0] M = 64'h4444_CCCC_22BB_AA11;
  logic        clk, nrst, termination_control, caseHot, pOe, pStr, sawCompl;
  logic        memClk, clockEnable, chipSelectN, rowStrobeN, colStrobeN, writeEnableN;
  logic [2:0]  bank_select;
  logic [13:0] address;
  logic        wdrive, lower_byte_mask, upper_byte_mask, lowerStrobeIn, upperStrobeIn;
  logic [15:0] wdata, dataIn, dataOut;
  logic        dataOeN, lower_byte_strobe, upper_byte_strobe, lowerStrobeCompl;
  logic        upperStrobeCompl, strobeOeN, complStrobeOeN, terminationOn;
  logic        selfRefreshOn, hotSelfRefreshOn, refreshLate;
  logic [15:0] rq[$];
  int          err_count, compares;
  // Released data lines show the inverse of the last value
  assign dataIn = !dataOeN ? dataOut : wdrive ? wdata : ~wdata;
  dsp_sdram dut_u (.*);
  dsp_ctrl_model m_u (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (!dataOeN && (pOe || lower_byte_strobe != pStr)) rq.push_back(dataOut);
    if (!complStrobeOeN) sawCompl <= 1'b1;
    pOe <= dataOeN;
    pStr <= lower_byte_strobe;
  end
  // ----
  // Scenarios
  // ----
  task automatic wr(input logic [2:0] b, input logic [13:0] a, input logic [63:0] d,
                    input logic [7:0] mk, input logic [3:0] c);
    m_u.cmd(c, b, a, 1'b1);
    m_u.burst(d, mk);
  endtask
  task automatic rd(input logic [2:0] b, input logic [63:0] e);
    rq = {};
    m_u.cmd(`DSP_CMD_READ, b, 14'h0004, 1'b1);
    m_u.tick(6);
    `CHK(rq.size(), 4)
    `CHK({rq[3], rq[2], rq[1], rq[0]}, e)
  endtask
  task automatic t_rw;
    m_u.cmd(`DSP_CMD_ACTIVATE, 3'h3, 14'h1ABC, 1'b1);
    m_u.cmd(`DSP_CMD_ACTIVATE, 3'h5, 14'h2001, 1'b1);
    wr(3'h3, 14'h0004, A, 8'h00, `DSP_CMD_WRITE);
    wr(3'h5, 14'h0404, ~A, 8'h00, `DSP_CMD_WRITE);
    rd(3'h3, A);
    m_u.cmd(`DSP_CMD_ACTIVATE, 3'h5, 14'h2001, 1'b1);
    rd(3'h5, ~A);
    $display("done read write");
  endtask
  task automatic t_mask;
    wr(3'h3, 14'h0004, 64'hDDDD_CCCC_BBBB_AAAA, 8'hC9, `DSP_CMD_WRITE);
    rd(3'h3, M);
    wr(3'h3, 14'h0004, 64'hEEEE_EEEE_EEEE_EEEE, 8'h00, 4'hC);
    rd(3'h3, M);
    $display("done mask and select");
  endtask
  task automatic t_diff;
    m_u.cmd(`DSP_CMD_MRS, `DSP_BANK_EMR1, 14'h0400, 1'b1);
    sawCompl = 1'b0;
    rd(3'h3, M);
    `CHK(sawCompl, 1'b1)
    m_u.cmd(`DSP_CMD_MRS, `DSP_BANK_EMR1, 14'h0000, 1'b1);
    sawCompl = 1'b0;
    rd(3'h3, M);
    `CHK(sawCompl, 1'b0)
    termination_control = 1'b1;
    m_u.tick(2);
    `CHK(terminationOn, 1'b1)
    termination_control = 1'b0;
    m_u.tick(2);
    `CHK(terminationOn, 1'b0)
    $display("done strobe mode and termination");
  endtask
  task automatic t_ref;
    m_u.cmd(`DSP_CMD_PRECHG, 3'h0, 14'h0400, 1'b1);
    m_u.cmd(`DSP_CMD_REFRESH, 3'h0, 14'h0000, 1'b1);
    repeat (500) @(posedge clk);
    #1 `CHK(refreshLate, 1'b0)
    repeat (400) @(posedge clk);
    #1 `CHK(refreshLate, 1'b1)
    caseHot = 1'b1;
    m_u.cmd(`DSP_CMD_REFRESH, 3'h0, 14'h0000, 1'b1);
    `CHK(refreshLate, 1'b0)
    repeat (300) @(posedge clk);
    #1 `CHK(refreshLate, 1'b0)
    repeat (150) @(posedge clk);
    #1 `CHK(refreshLate, 1'b1)
    $display("done refresh interval");
  endtask
  task automatic t_sr(input logic [13:0] e2, input logic [1:0] e);
    m_u.cmd(`DSP_CMD_MRS, `DSP_BANK_EMR2, e2, 1'b1);
    m_u.cmd(`DSP_CMD_REFRESH, 3'h0, 14'h0000, 1'b0);
    `CHK({selfRefreshOn, hotSelfRefreshOn}, e)
    m_u.cmd(`DSP_CMD_NOP, 3'h0, 14'h0000, 1'b1);
    `CHK({selfRefreshOn, hotSelfRefreshOn}, 2'b00)
    $display("done self refresh");
  endtask
  task automatic give_verdict;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    give_verdict;
  end
  initial begin
    {nrst, termination_control, caseHot, sawCompl} = 4'h0;
    {pOe, pStr} = 2'b10;
    err_count = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_rw;
    t_mask;
    t_diff;
    t_ref;
    t_sr(14'h0080, 2'b11);
    t_sr(14'h0000, 2'b10);
    give_verdict;
  end
endmodule
`default_nettype wire
